//--- src/timer_channel_pkg.sv
// Constants, register map and types shared by the timer channel block
`default_nettype none
// Behaviour
// R1: Trigger field picks software, valid edge, both edges or master interrupt start.
// R2: Edge field picks falling, rising, or both edges with start/capture split.
// R3: Mode field picks interval, capture, event, one-count, capture plus one-count.
// R4: Interval and capture: low mode bit set gives interrupt and toggle at start.
// R5: One-count: low mode bit chooses ignore or restart on start while counting.
// R6: Event and capture plus one-count give no start interrupt; latter ignores restarts.
// R7: Interval interrupt period is compare value plus one count clocks.
// R8: Output level register holds four channel levels; upper bits read zero.
// R9: Output enable clear: software writes the level bit and the pin follows.
// R10: Output enable set: timer waveform drives the bit; software writes ignored.
// R11: Invert bits pass or invert each external interrupt input.
// R12: Filter bits enable noise filter when clear, bypass it when set.
// R13: Second external input routes to interrupt with wake, or to timer restart.
// R14: First external input: interrupt with wake, or restart plus forced output stop.
// R15: Count clock select picks operation clock or channel input valid edges.
// R16: Operation clock field maps 00,01,10,11 to prescaler taps 0,2,1,3.
// R17: Interval down counter reloads at zero and pulses interrupt on each reload.
package timer_channel_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Word addresses of the register file
  localparam logic [ADDR_W-1:0] ADDR_MODE    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_PFS     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 4'h8;

  // channel_mode_config fields
  localparam int CKSEL_HI = 15;
  localparam int CKSEL_LO = 14;
  localparam int CCS_BIT  = 12;
  localparam int TRG_HI   = 10;
  localparam int TRG_LO   = 8;
  localparam int EDG_HI   = 7;
  localparam int EDG_LO   = 6;
  localparam int OPM_HI   = 3;
  localparam int OPM_LO   = 0;
  localparam logic [DATA_W-1:0] MODE_WMASK = 16'hd7cf;

  localparam logic [2:0] TRG_SOFT   = 3'h0;
  localparam logic [2:0] TRG_EDGE   = 3'h1;
  localparam logic [2:0] TRG_BOTH   = 3'h2;
  localparam logic [2:0] TRG_MASTER = 3'h4;

  localparam logic [1:0] EDG_FALL   = 2'h0;
  localparam logic [1:0] EDG_RISE   = 2'h1;
  localparam logic [1:0] EDG_LOW_W  = 2'h2;
  localparam logic [1:0] EDG_HIGH_W = 2'h3;

  localparam logic [2:0] OPM_INTERVAL = 3'h0;
  localparam logic [2:0] OPM_CAPTURE  = 3'h2;
  localparam logic [2:0] OPM_EVENT    = 3'h3;
  localparam logic [2:0] OPM_ONE      = 3'h4;
  localparam logic [2:0] OPM_CAP_ONE  = 3'h6;

  // Output level and enable
  localparam int LEVEL_W  = 4;
  localparam int ENABLE_W = 3;
  localparam int CH_BIT   = 1;

  // peripheral_function_switch fields
  localparam int PFS_W    = 8;
  localparam int INV_B    = 5;
  localparam int INV_A    = 4;
  localparam int NF_OFF_B = 3;
  localparam int NF_OFF_A = 2;
  localparam int RST_B    = 1;
  localparam int RST_A    = 0;

  // Status, mask and control bits
  localparam int ST_W       = 4;
  localparam int ST_TIMER   = 0;
  localparam int ST_CAPTURE = 1;
  localparam int ST_EXT_A   = 2;
  localparam int ST_EXT_B   = 3;
  localparam int CTL_START  = 0;
  localparam int CTL_STOP   = 1;

  // Reset values
  localparam logic [DATA_W-1:0]   MODE_RST    = 16'h0000;
  localparam logic [DATA_W-1:0]   COMPARE_RST = 16'h0000;
  localparam logic [LEVEL_W-1:0]  LEVEL_RST   = 4'h0;
  localparam logic [ENABLE_W-1:0] ENABLE_RST  = 3'h0;
  localparam logic [PFS_W-1:0]    PFS_RST     = 8'h00;
  localparam logic [ST_W-1:0]     STATUS_RST  = 4'h0;
  localparam logic [ST_W-1:0]     MASK_RST    = 4'h0;

  // Noise filter length in clock samples
  localparam int FILTER_LEN_DEF = 3;

  typedef enum logic {CH_IDLE, CH_RUN} ch_state_t;
endpackage : timer_channel_pkg
`default_nettype wire

//--- src/irq_path_if.sv
// Interface carrying one external interrupt line through its noise filter
`default_nettype none
interface irq_path_if;
  logic raw;
  logic filter_off;
  logic clean;
  modport filt (input raw, input filter_off, output clean);
  modport src  (output raw, output filter_off, input clean);
endinterface : irq_path_if
`default_nettype wire

//--- src/tick_divider.sv
// Clock enable divider producing one pulse every DIV cycles
`default_nettype none
module tick_divider #(
  parameter int unsigned DIV = 1
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;
  wire logic     at_last = (cnt_reg == LAST);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= at_last;
      cnt_reg  <= at_last ? '0 : cnt_reg + 1'b1;
    end
  end

  assign tick_o = tick_reg;
endmodule : tick_divider
`default_nettype wire

//--- src/noise_filter.sv
// Majority-free noise filter: level changes after LEN equal samples, or at once when filter_off is set
`default_nettype none
module noise_filter #(
  parameter int unsigned LEN = 3
) (
  input wire logic   clock_i,
  input wire logic   rst_n_i,
  irq_path_if.filt   path
);
  logic [LEN-1:0] hist_reg;
  logic           clean_reg;
  wire logic      all_high = &hist_reg;
  wire logic      all_low  = ~|hist_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_reg  <= '0;
      clean_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[LEN-2:0], path.raw};
      if (path.filter_off) begin
        clean_reg <= path.raw; // R12
      end else if (all_high) begin
        clean_reg <= 1'b1; // R12
      end else if (all_low) begin
        clean_reg <= 1'b0;
      end
    end
  end

  assign path.clean = clean_reg;
endmodule : noise_filter
`default_nettype wire

//--- src/timer_channel_mode_output_ctrl.sv
// Timer channel: mode decode, counter, output level control, external interrupt routing
`default_nettype none
module timer_channel_mode_output_ctrl
  import timer_channel_pkg::*;
#(
  parameter int unsigned CK_DIV [4] = '{1, 2, 4, 8},
  parameter int unsigned FILTER_LEN = FILTER_LEN_DEF
) (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  input  wire logic                channel_input_pin_i,
  input  wire logic                master_irq_i,
  input  wire logic                ext_irq_a_i,
  input  wire logic                ext_irq_b_i,
  output logic      [LEVEL_W-1:0]  output_pins_o,
  output logic                     channel_timer_irq_o,
  output logic      [1:0]          ext_irq_req_o,
  output logic                     stop_release_o,
  output logic                     forced_stop_o,
  output logic                     irq_o
);
  // Registers
  logic [DATA_W-1:0]   mode_reg;
  logic [DATA_W-1:0]   compare_reg;
  logic [DATA_W-1:0]   compare_next;
  logic [LEVEL_W-1:0]  level_reg;
  logic [LEVEL_W-1:0]  level_next;
  logic [ENABLE_W-1:0] enable_reg;
  logic [PFS_W-1:0]    pfs_reg;
  logic [ST_W-1:0]     status_reg;
  logic [ST_W-1:0]     status_next;
  logic [ST_W-1:0]     mask_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rd_val;
  logic                irq_reg;
  logic                timer_irq_reg;
  logic [1:0]          ext_req_reg;
  logic                stop_release_reg;
  logic                forced_stop_reg;

  // Counter state
  ch_state_t           state_reg;
  ch_state_t           state_next;
  logic [DATA_W-1:0]   counter_reg;
  logic [DATA_W-1:0]   counter_next;
  logic                timer_event;
  logic                capture_event;
  logic                toggle;

  // Input sampling
  logic                pin_d_reg;
  logic [1:0]          clean_d_reg;

  // Write decode
  wire logic wr_mode    = wr_i && (addr_i == ADDR_MODE);
  wire logic wr_compare = wr_i && (addr_i == ADDR_COMPARE);
  wire logic wr_level   = wr_i && (addr_i == ADDR_LEVEL);
  wire logic wr_enable  = wr_i && (addr_i == ADDR_ENABLE);
  wire logic wr_pfs     = wr_i && (addr_i == ADDR_PFS);
  wire logic wr_status  = wr_i && (addr_i == ADDR_STATUS);
  wire logic wr_mask    = wr_i && (addr_i == ADDR_MASK);
  wire logic wr_control = wr_i && (addr_i == ADDR_CONTROL);
  wire logic sw_start   = wr_control && wdata_i[CTL_START];
  wire logic sw_stop    = wr_control && wdata_i[CTL_STOP];

  // Mode field decode
  wire logic [1:0] op_clock_sel       = mode_reg[CKSEL_HI:CKSEL_LO];
  wire logic       count_clock_sel    = mode_reg[CCS_BIT];
  wire logic [2:0] trigger_source_sel = mode_reg[TRG_HI:TRG_LO];
  wire logic [1:0] input_edge_sel     = mode_reg[EDG_HI:EDG_LO];
  wire logic [3:0] op_mode_field      = mode_reg[OPM_HI:OPM_LO];
  wire logic [2:0] mode_base          = op_mode_field[3:1];
  wire logic       mode_lsb           = op_mode_field[0];

  wire logic is_interval = (mode_base == OPM_INTERVAL); // R3
  wire logic is_capture  = (mode_base == OPM_CAPTURE); // R3
  wire logic is_event    = (mode_base == OPM_EVENT) && !mode_lsb; // R3
  wire logic is_one      = (mode_base == OPM_ONE); // R3
  wire logic is_cap_one  = (mode_base == OPM_CAP_ONE) && !mode_lsb; // R3
  // Prohibited codes simply keep the channel idle
  wire logic mode_ok     = is_interval | is_capture | is_event | is_one | is_cap_one;
  wire logic down_mode   = is_interval | is_event | is_one; // R3
  wire logic cap_mode    = is_capture | is_cap_one;

  // Start interrupt and toggle only in interval and capture modes
  wire logic start_irq   = (is_interval | is_capture) && mode_lsb; // R4 R6
  // Restart while counting: one-count only with low bit set; capture+one-count never
  wire logic restartable = is_interval | is_capture | is_event | (is_one && mode_lsb); // R5 R6

  // Channel input edges
  wire logic pin_rise = channel_input_pin_i && !pin_d_reg;
  wire logic pin_fall = !channel_input_pin_i && pin_d_reg;
  wire logic valid_edge =
    (input_edge_sel == EDG_FALL) ? pin_fall :
    (input_edge_sel == EDG_RISE) ? pin_rise : (pin_rise | pin_fall); // R2
  wire logic start_edge =
    (input_edge_sel == EDG_LOW_W)  ? pin_fall :
    (input_edge_sel == EDG_HIGH_W) ? pin_rise : valid_edge; // R2
  wire logic capture_edge =
    (input_edge_sel == EDG_LOW_W)  ? pin_rise :
    (input_edge_sel == EDG_HIGH_W) ? pin_fall : valid_edge; // R2

  // Trigger source; prohibited codes act as software-only
  wire logic hw_start =
    (trigger_source_sel == TRG_EDGE)   ? valid_edge :
    (trigger_source_sel == TRG_BOTH)   ? start_edge :
    (trigger_source_sel == TRG_MASTER) ? master_irq_i : 1'b0; // R1
  wire logic hw_capture =
    (trigger_source_sel == TRG_EDGE) ? valid_edge :
    (trigger_source_sel == TRG_BOTH) ? capture_edge : 1'b0; // R1

  // Prescaler taps and count clock
  logic [3:0] ck_tick;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tap
      tick_divider #(
        .DIV (CK_DIV[g])
      ) u_div (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_o  (ck_tick[g])
      );
    end
  endgenerate

  wire logic [1:0] tap_idx    = {op_clock_sel[0], op_clock_sel[1]}; // R16
  wire logic       op_tick    = ck_tick[tap_idx]; // R16
  wire logic       count_tick = count_clock_sel ? valid_edge : op_tick; // R15

  // External interrupt inputs: invert, filter, route
  irq_path_if path_a ();
  irq_path_if path_b ();

  assign path_a.raw        = ext_irq_a_i ^ pfs_reg[INV_A]; // R11
  assign path_b.raw        = ext_irq_b_i ^ pfs_reg[INV_B]; // R11
  assign path_a.filter_off = pfs_reg[NF_OFF_A]; // R12
  assign path_b.filter_off = pfs_reg[NF_OFF_B]; // R12

  noise_filter #(
    .LEN (FILTER_LEN)
  ) u_filt_a (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .path    (path_a)
  );

  noise_filter #(
    .LEN (FILTER_LEN)
  ) u_filt_b (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .path    (path_b)
  );

  wire logic [1:0] clean       = {path_b.clean, path_a.clean};
  wire logic [1:0] ext_rise    = clean & ~clean_d_reg;
  wire logic [1:0] restart_sel = {pfs_reg[RST_B], pfs_reg[RST_A]};
  // Routed lines either interrupt and wake, or restart the timer
  wire logic [1:0] ext_req     = ext_rise & ~restart_sel; // R13 R14
  wire logic       ext_restart = |(ext_rise & restart_sel); // R13 R14
  wire logic       start_any   = sw_start | hw_start | ext_restart;

  // Counter state machine
  always_comb begin
    state_next    = state_reg;
    counter_next  = counter_reg;
    timer_event   = 1'b0;
    capture_event = 1'b0;
    toggle        = 1'b0;
    case (state_reg)
      CH_IDLE: begin
        if (start_any && mode_ok) begin
          state_next   = CH_RUN;
          counter_next = down_mode ? compare_reg : '0;
          if (start_irq) begin
            timer_event = 1'b1; // R4
            toggle      = 1'b1; // R4
          end
        end
      end
      CH_RUN: begin
        if (!mode_ok || sw_stop) begin
          state_next = CH_IDLE;
        end else if (cap_mode && hw_capture) begin
          // Capture beats a coincident start on the same edge
          capture_event = 1'b1;
          timer_event   = 1'b1;
          counter_next  = '0;
          if (is_cap_one) begin
            state_next = CH_IDLE;
          end
        end else if (start_any && restartable) begin
          counter_next = down_mode ? compare_reg : '0; // R5
        end else if (count_tick) begin
          if (!down_mode) begin
            counter_next = counter_reg + 1'b1;
          end else if (counter_reg == '0) begin
            timer_event = 1'b1; // R7 R17
            toggle      = 1'b1;
            if (is_one) begin
              state_next = CH_IDLE;
            end else begin
              counter_next = compare_reg; // R7 R17
            end
          end else begin
            counter_next = counter_reg - 1'b1;
          end
        end
      end
      default: begin
        state_next = CH_IDLE;
      end
    endcase
  end

  // Capture overwrites the compare register; hardware wins a coincident write
  assign compare_next = capture_event ? counter_reg :
                        wr_compare    ? wdata_i : compare_reg;

  // Level bits under an enable are closed to software
  wire logic [LEVEL_W-1:0] level_wmask = ~{1'b0, enable_reg}; // R9 R10
  wire logic [LEVEL_W-1:0] level_sw =
    (level_reg & ~level_wmask) | (wdata_i[LEVEL_W-1:0] & level_wmask); // R8 R9
  wire logic               ch_toggle = toggle && enable_reg[CH_BIT]; // R10

  always_comb begin
    level_next = wr_level ? level_sw : level_reg; // R9
    if (ch_toggle) begin
      level_next[CH_BIT] = ~level_reg[CH_BIT]; // R10
    end
  end

  // Sticky status: set wins over write-one-to-clear
  wire logic [ST_W-1:0] status_set =
    {ext_req[1], ext_req[0], capture_event, timer_event};
  wire logic [ST_W-1:0] status_clr = wr_status ? wdata_i[ST_W-1:0] : '0;
  assign status_next = (status_reg & ~status_clr) | status_set;

  // Read selection
  always_comb begin
    case (addr_i)
      ADDR_MODE:    rd_val = mode_reg;
      ADDR_COMPARE: rd_val = compare_reg;
      ADDR_LEVEL:   rd_val = DATA_W'(level_reg); // R8
      ADDR_ENABLE:  rd_val = DATA_W'(enable_reg);
      ADDR_PFS:     rd_val = DATA_W'(pfs_reg);
      ADDR_STATUS:  rd_val = DATA_W'(status_reg);
      ADDR_MASK:    rd_val = DATA_W'(mask_reg);
      ADDR_CONTROL: rd_val = DATA_W'(state_reg == CH_RUN);
      ADDR_COUNTER: rd_val = counter_reg;
      default:      rd_val = '0;
    endcase
  end

  // Register file
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg    <= MODE_RST;
      compare_reg <= COMPARE_RST;
      level_reg   <= LEVEL_RST;
      enable_reg  <= ENABLE_RST;
      pfs_reg     <= PFS_RST;
      status_reg  <= STATUS_RST;
      mask_reg    <= MASK_RST;
      rdata_reg   <= '0;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata_i & MODE_WMASK;
      end
      if (wr_enable) begin
        enable_reg <= wdata_i[ENABLE_W-1:0];
      end
      if (wr_pfs) begin
        pfs_reg <= wdata_i[PFS_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wdata_i[ST_W-1:0];
      end
      compare_reg <= compare_next;
      level_reg   <= level_next;
      status_reg  <= status_next;
      rdata_reg   <= rd_i ? rd_val : '0;
    end
  end

  // Counter, edge history and outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg        <= CH_IDLE;
      counter_reg      <= '0;
      pin_d_reg        <= 1'b0;
      clean_d_reg      <= 2'b00;
      timer_irq_reg    <= 1'b0;
      ext_req_reg      <= 2'b00;
      stop_release_reg <= 1'b0;
      forced_stop_reg  <= 1'b0;
      irq_reg          <= 1'b0;
    end else begin
      state_reg        <= state_next;
      counter_reg      <= counter_next;
      pin_d_reg        <= channel_input_pin_i;
      clean_d_reg      <= clean;
      timer_irq_reg    <= timer_event; // R17
      ext_req_reg      <= ext_req; // R13 R14
      stop_release_reg <= |ext_req; // R13 R14
      forced_stop_reg  <= restart_sel[0] && clean[0]; // R14
      irq_reg          <= |(status_next & mask_reg);
    end
  end

  assign rdata_o             = rdata_reg;
  assign output_pins_o       = level_reg;
  assign channel_timer_irq_o = timer_irq_reg;
  assign ext_irq_req_o       = ext_req_reg;
  assign stop_release_o      = stop_release_reg;
  assign forced_stop_o       = forced_stop_reg;
  assign irq_o               = irq_reg;
endmodule : timer_channel_mode_output_ctrl
`default_nettype wire

//--- sim/timer_channel_asserts.sv
// Concurrent checks on the timer channel top-level ports
`default_nettype none
module timer_channel_asserts
  import timer_channel_pkg::*;
(
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic [ADDR_W-1:0]  addr_i,
  input wire logic [DATA_W-1:0]  wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [DATA_W-1:0]  rdata_o,
  input wire logic               channel_input_pin_i,
  input wire logic               master_irq_i,
  input wire logic               ext_irq_a_i,
  input wire logic               ext_irq_b_i,
  input wire logic [LEVEL_W-1:0] output_pins_o,
  input wire logic               channel_timer_irq_o,
  input wire logic [1:0]         ext_irq_req_o,
  input wire logic               stop_release_o,
  input wire logic               forced_stop_o,
  input wire logic               irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mode_reg;
  logic [DATA_W-1:0] cmp_reg;
  logic [PFS_W-1:0]  pfs_reg;
  logic [ST_W-1:0]   mask_reg;
  logic              cfg_ok;
  // Shadows of the settings that gate the checks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= '0;
      cmp_reg <= '0;
      pfs_reg <= '0;
      mask_reg <= '0;
    end else if (wr_i) begin
      if (addr_i == ADDR_MODE) mode_reg <= wdata_i;
      if (addr_i == ADDR_COMPARE) cmp_reg <= wdata_i;
      if (addr_i == ADDR_PFS) pfs_reg <= wdata_i[PFS_W-1:0];
      if (addr_i == ADDR_MASK) mask_reg <= wdata_i[ST_W-1:0];
    end
  end
  // Plain interval on tap zero only; start pulses and restarts would skew spacing
  assign cfg_ok = (mode_reg & 16'hd70f) == '0 && cmp_reg == 16'h0002 && pfs_reg[1:0] == 2'h0;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_event_settled; channel_timer_irq_o && cfg_ok && !wr_i; endsequence
  sequence s_two_quiet; (cfg_ok && !wr_i) [*2] ##1 1'b1; endsequence
  sequence s_a_rise;
    $changed(ext_irq_a_i) && (ext_irq_a_i ^ pfs_reg[INV_A]) && pfs_reg[NF_OFF_A] && !pfs_reg[RST_A];
  endsequence
  sequence s_b_rise;
    $changed(ext_irq_b_i) && (ext_irq_b_i ^ pfs_reg[INV_B]) && pfs_reg[NF_OFF_B] && !pfs_reg[RST_B];
  endsequence
  a_irq_period: assert property (s_event_settled ##1 s_two_quiet |->
    channel_timer_irq_o && !$past(channel_timer_irq_o) && !$past(channel_timer_irq_o, 2))
    else $error("interval interrupt spacing wrong");
  a_ext_a_req: assert property (s_a_rise |-> ##[2:4] ext_irq_req_o[0])
    else $error("first line edge gave no request");
  a_ext_b_req: assert property (s_b_rise |-> ##[2:4] ext_irq_req_o[1])
    else $error("second line edge gave no request");
  a_req_a_route: assert property (ext_irq_req_o[0] |-> !$past(pfs_reg[RST_A]))
    else $error("first line request while routed to restart");
  a_req_b_route: assert property (ext_irq_req_o[1] |-> !$past(pfs_reg[RST_B]))
    else $error("second line request while routed to restart");
  a_forced_route: assert property (forced_stop_o |-> $past(pfs_reg[RST_A]))
    else $error("forced stop without restart routing");
  a_release_req: assert property (|ext_irq_req_o |-> ##[0:1] stop_release_o)
    else $error("request gave no stop release");
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_i && addr_i > ADDR_COUNTER |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_level_upper: assert property (rd_i && addr_i == ADDR_LEVEL |=> rdata_o[15:4] == '0)
    else $error("level upper bits not zero");
  a_irq_masked: assert property (irq_o |-> (mask_reg | $past(mask_reg)) != '0)
    else $error("interrupt with all sources masked");
endmodule // timer_channel_asserts
`default_nettype wire

//--- sim/tb_timer_channel_mode_output_ctrl.sv
// Self-checking bench for the timer channel block
`default_nettype none
module tb_timer_channel_mode_output_ctrl
  import timer_channel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0]  exp_q[$];
  logic               clock_i, rst_n_i, wr_i, rd_i, rd_q, ext_a, ext_b, ev, pin, mst;
  logic               tirq_o, rel_o, fstop_o, irq_o;
  logic [ADDR_W-1:0]  addr_i;
  logic [DATA_W-1:0]  wdata_i, rdata_o, val;
  logic [LEVEL_W-1:0] pins_o;
  logic [1:0]         req_o;
  int                 fail_count, num_checks, cyc, n, cmp;

  timer_channel_mode_output_ctrl dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .channel_input_pin_i(pin), .master_irq_i(mst),
    .ext_irq_a_i(ext_a), .ext_irq_b_i(ext_b), .output_pins_o(pins_o),
    .channel_timer_irq_o(tirq_o), .ext_irq_req_o(req_o), .stop_release_o(rel_o),
    .forced_stop_o(fstop_o), .irq_o(irq_o));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // Expected read data goes to the queue; the monitor pops it when data appear
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (tirq_o !== 1'b1 && k < 300);
  endtask

  always @(posedge clock_i) begin
    rd_q <= rd_i;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Sampled mid-cycle, away from the edge that updates the outputs
  always @(negedge clock_i) begin
    if (tirq_o === 1'b1) ev = ~ev;
    if (rd_q === 1'b1) chk("rdata", exp_q.pop_front(), rdata_o);
  end

  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    ext_a = 1'b0;
    ext_b = 1'b0;
    ev = 1'b0;
    pin = 1'b0;
    mst = 1'b0;
    void'($urandom(32'h23f8cd6b));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), '0);
    val = 16'($urandom);
    wr(ADDR_MODE, val);
    rd(ADDR_MODE, val & MODE_WMASK);
    wr(ADDR_COMPARE, ~val);
    rd(ADDR_COMPARE, ~val);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_ENABLE, 16'h0000);
    wr(ADDR_LEVEL, val);
    rd(ADDR_LEVEL, {12'h000, val[3:0]});
    chk("pins", 16'(val[3:0]), 16'(pins_o));
    wr(ADDR_ENABLE, 16'h0002);
    wr(ADDR_LEVEL, ~val);
    rd(ADDR_LEVEL, {12'h000, ~val[3:2], val[1], ~val[0]});
    wr(ADDR_MASK, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      cmp = (i == 0) ? 2 : 1 + $urandom % 6;
      wr(ADDR_COMPARE, 16'(cmp));
      wr(ADDR_CONTROL, 16'h0001);
      wait_irq(n);
      chk("first_irq", 16'(cmp + 2), 16'(n));
      wait_irq(n);
      chk("period", 16'(cmp + 1), 16'(n));
      wr(ADDR_CONTROL, 16'h0002);
      chk("irq_o", 16'h1, 16'(irq_o));
      wr(ADDR_MASK, 16'h0000);
      rd(ADDR_MASK, 16'h0000);
      chk("irq_masked", 16'h0, 16'(irq_o));
      wr(ADDR_MASK, 16'h0001);
      wr(ADDR_STATUS, 16'h0001);
      rd(ADDR_STATUS, 16'h0000);
      chk("irq_clear", 16'h0, 16'(irq_o));
      chk("pin_toggle", 16'(val[1] ^ ev), 16'(pins_o[CH_BIT]));
    end
    wr(ADDR_MODE, 16'h0001);
    wr(ADDR_CONTROL, 16'h0001);
    wait_irq(n);
    chk("start_irq", 16'h1, 16'(n <= 2));
    wr(ADDR_CONTROL, 16'h0002);
    // Second start lands two cycles into the count
    for (int b = 0; b < 2; b++) begin
      wr(ADDR_STATUS, 16'h000f);
      wr(ADDR_MODE, 16'(8 + b));
      wr(ADDR_CONTROL, 16'h0001);
      wr(ADDR_CONTROL, 16'h0001);
      wait_irq(n);
      chk("one_count", 16'(b ? cmp + 2 : cmp), 16'(n));
      wr(ADDR_CONTROL, 16'h0002);
    end
    wr(ADDR_MODE, 16'h0140);
    pin <= 1'b1;
    wait_irq(n);
    chk("edge_start", 16'(cmp + 3), 16'(n));
    wr(ADDR_CONTROL, 16'h0002);
    wr(ADDR_MODE, 16'h0400);
    mst <= 1'b1;
    @(posedge clock_i) mst <= 1'b0;
    wait_irq(n);
    chk("master_start", 16'(cmp + 2), 16'(n));
    wr(ADDR_CONTROL, 16'h0002);
    wr(ADDR_MASK, 16'h000c);
    wr(ADDR_STATUS, 16'h000f);
    wr(ADDR_PFS, 16'h000c);
    ext_a <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(ADDR_STATUS, 16'h0004);
    chk("irq_ext", 16'h1, 16'(irq_o));
    wr(ADDR_PFS, 16'h001c);
    wr(ADDR_STATUS, 16'h000f);
    ext_a <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(ADDR_STATUS, 16'h0004);
    wr(ADDR_PFS, 16'h001d);
    repeat (4) @(posedge clock_i);
    chk("forced_stop", 16'h1, 16'(fstop_o));
    wr(ADDR_PFS, 16'h0000);
    wr(ADDR_STATUS, 16'h000f);
    // Glitch shorter than the filter length must vanish
    ext_b <= 1'b1;
    repeat (1 + $urandom % 2) @(posedge clock_i);
    ext_b <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(ADDR_STATUS, 16'h0000);
    wr(ADDR_PFS, 16'h0008);
    ext_b <= 1'b1;
    repeat (10) @(posedge clock_i);
    rd(ADDR_STATUS, 16'h0008);
    wr(ADDR_MODE, 16'h0000);
    ext_b <= 1'b0;
    repeat (8) @(posedge clock_i);
    wr(ADDR_STATUS, 16'h000f);
    wr(ADDR_PFS, 16'h000a);
    ext_b <= 1'b1;
    wait_irq(n);
    chk("restart_b", 16'h1, 16'(n < 30));
    wr(ADDR_CONTROL, 16'h0002);
    rd(ADDR_STATUS, 16'h0001);
    repeat (3) @(posedge clock_i);
    report_and_stop();
  end
endmodule // tb_timer_channel_mode_output_ctrl

bind timer_channel_mode_output_ctrl timer_channel_asserts u_chk (.clock_i, .rst_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .channel_input_pin_i, .master_irq_i, .ext_irq_a_i,
  .ext_irq_b_i, .output_pins_o, .channel_timer_irq_o, .ext_irq_req_o, .stop_release_o,
  .forced_stop_o, .irq_o);
`default_nettype wire
